// File: mvb_port.sv
/*
  Pin-level port of the microcontroller: program address and instruction
  bus, the active-low three-state vector bus with its strobes and group
  enables, the master clock output, reset and halt handling.
  Assumes program storage answers within one instruction cycle and that
  the board resolves the vector bus wire from the enables.
*/
// What this block does
// - Drive 13-bit program address, bit 12 LSB.
// - Sample 16-bit instruction word, bit 0 LSB.
// - Select strobe high only while address driven.
// - Write strobe high while driving bus data.
// - Left enable low when left group accessed.
// - Right enable low when right group accessed.
// - Vector bus is active low, line 7 LSB.
// - Provide active-high master clock output.
// - Reset clears counter, address, stops clock.
// - Reset forces both group enables high immediately.
// - Halt stops execution at next cycle start.
// - Halt keeps clock running, registers unchanged.
// - Halt drives enables high in first quarter.
// - Up to 256 ports per group selectable.
`timescale 1ns/1ps
module mvb_port
  import mvb_pkg::*;
(
  // Clock, reset and halt.
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic i_halt_n,
  // Program bus.
  output logic [MVB_ADDR_W-1:0] o_program_address_lines,
  input wire logic [MVB_INSTR_W-1:0] i_instruction_lines,
  // Vector bus, pin bit 0 carries the most significant bit.
  input wire logic [MVB_BUS_W-1:0] i_vector_bus_n,
  output logic [MVB_BUS_W-1:0] o_vector_bus_n,
  output logic o_vector_bus_oe_n,
  // Strobes and clock.
  output logic o_address_select_strobe,
  output logic o_data_write_strobe,
  output logic o_left_group_enable_n,
  output logic o_right_group_enable_n,
  output logic o_master_clock,
  // Last byte read from the bus, in true polarity with bit 0 as LSB.
  output logic [MVB_BUS_W-1:0] o_read_data
);
  mvb_quarter_t quarter;
  logic quarter_end;
  logic [MVB_ADDR_W-1:0] pc;
  logic [MVB_INSTR_W-1:0] instr;
  logic running;
  logic halted;
  mvb_ctrl_t ctrl;
  logic drive;
  logic [MVB_ADDR_W-1:0] next_pc;

  mvb_phase u_phase (
    .i_mclk(i_mclk),
    .i_reset(i_reset),
    .o_quarter(quarter),
    .o_quarter_end(quarter_end)
  );

  mvb_decode u_decode (
    .i_instr(instr),
    .i_pc(pc),
    .o_ctrl(ctrl),
    .o_drive(drive),
    .o_next_pc(next_pc)
  );

  // Pin bit order is reversed against internal order; the low level means one.
  function automatic logic [7:0] to_pins(input logic [7:0] value);
    logic [7:0] r;
    for (int i = 0; i < 8; i++) begin
      r[i] = ~value[7 - i];
    end
    return r;
  endfunction

  wire cycle_start = quarter_end && (quarter == MVB_Q3);
  wire q1_end = quarter_end && (quarter == MVB_Q0);
  wire q3_end = quarter_end && (quarter == MVB_Q2);
  wire bus_active = running && !halted;
  // The instruction's own low byte is the address or data sent out.
  wire [7:0] out_byte = instr[7:0];
  wire [7:0] next_pins = to_pins(out_byte);
  wire [MVB_ADDR_W-1:0] next_addr_pins = {<<{next_pc}};

  // Halt takes effect only on a cycle boundary, so an instruction in
  // flight always completes its bus transfer.
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      halted <= 1'b0;
      running <= 1'b0;
    end else if (cycle_start) begin
      halted <= !i_halt_n;
      running <= 1'b1;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      pc <= MVB_PC_RESET;
      o_program_address_lines <= MVB_PC_RESET;
      instr <= '0;
    end else if (cycle_start && i_halt_n) begin
      instr <= i_instruction_lines;
      pc <= next_pc;
      o_program_address_lines <= next_addr_pins;
    end
  end

  // Master clock is high in the second and third quarters of each cycle and keeps
  // running through halt; it stays low under reset.
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      o_master_clock <= 1'b0;
    end else if (q1_end) begin
      o_master_clock <= 1'b1;
    end else if (q3_end) begin
      o_master_clock <= 1'b0;
    end
  end

  // Controls change at cycle start and stand for the whole cycle. During
  // halt the enables go high at the cycle start, inside the first quarter.
  wire issue = i_halt_n && running;

  // The enables alone take reset without waiting for a clock edge, so every
  // port lets go of the bus the moment reset rises; the rest stays synchronous.
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      o_left_group_enable_n <= 1'b1;
      o_right_group_enable_n <= 1'b1;
    end else if (cycle_start) begin
      if (issue) begin
        o_left_group_enable_n <= ctrl.left_group_enable_n;
        o_right_group_enable_n <= ctrl.right_group_enable_n;
      end else begin
        o_left_group_enable_n <= 1'b1;
        o_right_group_enable_n <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      o_address_select_strobe <= 1'b0;
      o_data_write_strobe <= 1'b0;
      o_vector_bus_oe_n <= 1'b1;
      o_vector_bus_n <= MVB_BUS_IDLE;
    end else if (cycle_start) begin
      if (issue) begin
        o_address_select_strobe <= ctrl.address_select_strobe;
        o_data_write_strobe <= ctrl.data_write_strobe;
        o_vector_bus_oe_n <= !drive;
        o_vector_bus_n <= drive ? next_pins : MVB_BUS_IDLE;
      end else begin
        o_address_select_strobe <= 1'b0;
        o_data_write_strobe <= 1'b0;
        o_vector_bus_oe_n <= 1'b1;
        o_vector_bus_n <= MVB_BUS_IDLE;
      end
    end
  end

  // A read takes the port's byte at the falling master clock, when the
  // port has had three quarters of a cycle to drive it.
  wire read_now = q3_end && bus_active && o_vector_bus_oe_n && !o_data_write_strobe
                  && !(o_left_group_enable_n && o_right_group_enable_n);
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      o_read_data <= '0;
    end else if (read_now) begin
      o_read_data <= to_pins(i_vector_bus_n);
    end
  end
endmodule

// File: mvb_pkg.sv
/*
  Shared constants and carrier types for the vector bus port of the
  microcontroller. Assumes a single 200 MHz clock and no software registers.
*/
package mvb_pkg;
  localparam int MVB_ADDR_W = 13;
  localparam int MVB_INSTR_W = 16;
  localparam int MVB_BUS_W = 8;
  localparam int MVB_PROG_WORDS = 8192;
  // Instruction cycle of 200 ns, split into four quarters.
  localparam int MVB_CYCLE_NS = 200;
  localparam int MVB_CLK_NS = 5;
  localparam int MVB_QUARTER_CYCLES = MVB_CYCLE_NS / MVB_CLK_NS / 4;
  localparam logic [12:0] MVB_PC_RESET = 13'h0000;
  localparam logic [7:0] MVB_BUS_IDLE = 8'hff;
  // Instruction field layout, chosen for this port: operation in the top bits.
  localparam int MVB_OP_HI = 15;
  localparam int MVB_OP_LO = 13;
  localparam logic [2:0] MVB_OP_SELECT = 3'h1;
  localparam logic [2:0] MVB_OP_WRITE = 3'h2;
  localparam logic [2:0] MVB_OP_READ = 3'h3;
  localparam logic [2:0] MVB_OP_JUMP = 3'h4;
  localparam int MVB_RIGHT_BIT = 12;
  localparam int MVB_LEFT_BIT = 11;

  typedef struct packed {
    logic address_select_strobe;
    logic data_write_strobe;
    logic left_group_enable_n;
    logic right_group_enable_n;
  } mvb_ctrl_t;

  typedef enum logic [1:0] {MVB_Q0, MVB_Q1, MVB_Q2, MVB_Q3} mvb_quarter_t;
endpackage

// File: mvb_phase.sv
/*
  Quarter-cycle sequencer: divides the system clock into the four
  quarters of one instruction cycle. Assumes synchronous reset.
*/
`timescale 1ns/1ps
module mvb_phase
  import mvb_pkg::*;
(
  // Clock and reset.
  input wire logic i_mclk,
  input wire logic i_reset,
  // Quarter state.
  output mvb_quarter_t o_quarter,
  output logic o_quarter_end
);
  logic [7:0] count;
  wire last = (count == 8'(MVB_QUARTER_CYCLES - 1));

  assign o_quarter_end = last;

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      count <= 8'h00;
      o_quarter <= MVB_Q0;
    end else if (last) begin
      count <= 8'h00;
      o_quarter <= mvb_quarter_t'(o_quarter + 2'h1);
    end else begin
      count <= count + 8'h01;
    end
  end
endmodule

// File: mvb_decode.sv
/*
  Instruction decoder: turns a fetched instruction word into the bus
  controls, drive flag and the next program address. Purely combinational.
*/
`timescale 1ns/1ps
module mvb_decode
  import mvb_pkg::*;
(
  // Current state.
  input wire logic [MVB_INSTR_W-1:0] i_instr,
  input wire logic [MVB_ADDR_W-1:0] i_pc,
  // Decoded result.
  output mvb_ctrl_t o_ctrl,
  output logic o_drive,
  output logic [MVB_ADDR_W-1:0] o_next_pc
);
  wire [2:0] op = i_instr[MVB_OP_HI:MVB_OP_LO];
  wire is_sel = (op == MVB_OP_SELECT);
  wire is_wr = (op == MVB_OP_WRITE);
  wire is_rd = (op == MVB_OP_READ);
  wire is_bus = is_sel | is_wr | is_rd;

  assign o_ctrl.address_select_strobe = is_sel;
  assign o_ctrl.data_write_strobe = is_wr;
  assign o_ctrl.left_group_enable_n = ~(is_bus & i_instr[MVB_LEFT_BIT]);
  assign o_ctrl.right_group_enable_n = ~(is_bus & i_instr[MVB_RIGHT_BIT]);
  assign o_drive = is_sel | is_wr;
  assign o_next_pc = (op == MVB_OP_JUMP) ? i_instr[MVB_ADDR_W-1:0] : i_pc + 13'h0001;
endmodule

// File: mvb_port_props.sv
/* Checker on the port pins.
   Assumes a bind to mvb_port. */
`timescale 1ns/1ps
module mvb_port_props
  import mvb_pkg::*;
(
  // Clock, reset, halt.
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic i_halt_n,
  // Outputs watched.
  input wire logic [MVB_ADDR_W-1:0] o_program_address_lines,
  input wire logic [MVB_BUS_W-1:0] o_vector_bus_n,
  input wire logic o_vector_bus_oe_n,
  input wire logic o_address_select_strobe,
  input wire logic o_data_write_strobe,
  input wire logic o_left_group_enable_n,
  input wire logic o_right_group_enable_n,
  input wire logic o_master_clock
);
  wire sel = o_address_select_strobe;
  wire wr = o_data_write_strobe;
  wire oe_n = o_vector_bus_oe_n;
  wire en = o_left_group_enable_n && o_right_group_enable_n;
  wire mc = o_master_clock;
  wire [12:0] pa = o_program_address_lines;
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_reset);
  sequence s_20(x); x[*8] ##1 x[*8] ##1 x[*4]; endsequence
  sequence s_hlt; (!i_halt_n)[*8] ##1 (!i_halt_n)[*4] ##1 $rose(mc); endsequence
  property p_sel; sel || wr |-> !oe_n; endproperty
  property p_drv; !oe_n |-> sel || wr; endproperty
  property p_idle; oe_n |-> o_vector_bus_n == MVB_BUS_IDLE; endproperty
  property p_hi; $rose(mc) |-> s_20(mc) ##1 !mc; endproperty
  property p_lo; $fell(mc) |-> s_20(!mc) ##1 mc; endproperty
  property p_hen; s_hlt |-> en && !sel && !wr; endproperty
  property p_hpc; s_hlt |-> pa == $past(pa, 12); endproperty
  property p_rst; disable iff (1'b0) i_reset |=> pa == MVB_PC_RESET && en && !mc; endproperty
  a_sel: assert property (p_sel) else $error("strobe, no drive");
  a_drv: assert property (p_drv) else $error("drive, no strobe");
  a_idle: assert property (p_idle) else $error("idle bus");
  a_hi: assert property (p_hi) else $error("clock high");
  a_lo: assert property (p_lo) else $error("clock low");
  a_hen: assert property (p_hen) else $error("halt enables");
  a_hpc: assert property (p_hpc) else $error("halt address");
  a_rst: assert property (p_rst) else $error("reset state");
endmodule

// File: mvb_io_model.sv
/* Behavioural I/O port on the left group.
   Assumes device pins wired in; it resolves the bus. */
`timescale 1ns/1ps
module mvb_io_model
  import mvb_pkg::*;
(
  // Device side.
  input wire logic i_mc,
  input wire mvb_ctrl_t i_ctrl,
  input wire logic [7:0] i_dev_n,
  input wire logic i_dev_oe_n,
  // Wire seen by the device.
  output logic [7:0] o_wire_n
);
  logic [7:0] mem [256];
  logic [7:0] addr = 8'h00;
  logic [7:0] last = 8'h00;
  wire on = !i_ctrl.left_group_enable_n;
  wire drv = on && !i_ctrl.address_select_strobe && !i_ctrl.data_write_strobe;
  wire [7:0] din = {<<{~i_dev_n}};
  wire [7:0] dout = {<<{~mem[addr]}};
  // No pull-up: a released bus shows the inverse of its last level.
  assign o_wire_n = !i_dev_oe_n ? i_dev_n : drv ? dout : ~last;
  always @(posedge i_mc) begin
    if (on && i_ctrl.address_select_strobe) addr <= din;
    if (on && i_ctrl.data_write_strobe) mem[addr] <= din;
    last <= o_wire_n;
  end
endmodule

// File: mvb_port_tb_top.sv
/* Top testbench: program store, port model, scenarios.
   Assumes package, design, checker and model come first. */
`timescale 1ns/1ps
module mvb_port_tb_top
  import mvb_pkg::*;
;
  logic i_mclk = 0;
  logic i_reset = 1;
  logic i_halt_n = 1;
  logic [15:0] instr = 16'h0;
  logic [12:0] pa, pc;
  logic [7:0] vec_n, bus_n, rd;
  logic oe_n, mc;
  wire mvb_ctrl_t ctrl;
  wire [1:0] en = {ctrl.left_group_enable_n, ctrl.right_group_enable_n};
  logic [15:0] prog [4] = '{16'h2835, 16'h481e, 16'h7800, 16'h8000};
  int err_count = 0;
  int total_checks = 0;
  always #2.5 i_mclk = ~i_mclk;
  assign pc = {<<{pa}};
  always @(posedge i_mclk) instr <= prog[pc[1:0]];
  mvb_port u_dut (.i_mclk, .i_reset, .i_halt_n, .o_program_address_lines(pa),
    .i_instruction_lines(instr), .i_vector_bus_n(bus_n), .o_vector_bus_n(vec_n),
    .o_vector_bus_oe_n(oe_n), .o_address_select_strobe(ctrl.address_select_strobe),
    .o_data_write_strobe(ctrl.data_write_strobe), .o_left_group_enable_n(ctrl.left_group_enable_n),
    .o_right_group_enable_n(ctrl.right_group_enable_n), .o_master_clock(mc), .o_read_data(rd));
  mvb_io_model u_io (.i_mc(mc), .i_ctrl(ctrl), .i_dev_n(vec_n), .i_dev_oe_n(oe_n), .o_wire_n(bus_n));
  task automatic chk(string s, logic [15:0] e, logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s exp %h got %h", s, e, g);
    end
  endtask
  task automatic close_out;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic wt(input bit w);
    int n;
    for (n = 0; n < 200 && (w ? ctrl.data_write_strobe : ctrl.address_select_strobe) !== 1; n++)
      @(negedge i_mclk);
    if (n == 200) begin
      err_count++;
      close_out;
    end
  endtask
  task automatic rst_chk;
    @(negedge i_mclk);
    chk("rst addr", 0, pa);
    chk("rst en", 3, en);
    chk("rst mclk", 0, mc);
    @(posedge i_mclk) i_reset <= 0;
  endtask
  task automatic t_sel;
    wt(0);
    chk("sel bus", 8'({<<{~8'h35}}), vec_n);
    chk("sel en", 1, en);
    chk("sel oe", 0, oe_n);
  endtask
  task automatic t_rst_now;
    @(posedge i_mclk) i_reset <= 1;
    #1;
    chk("rst en now", 3, en);
    @(posedge i_mclk);
    rst_chk;
  endtask
  task automatic t_wr;
    wt(1);
    chk("wr bus", 8'({<<{~8'h1e}}), vec_n);
    chk("wr en", 1, en);
    chk("wr oe", 0, oe_n);
    repeat (75) @(negedge i_mclk);
    chk("rd oe", 1, oe_n);
    chk("rd wr", 0, ctrl.data_write_strobe);
    chk("rd en", 0, en);
    chk("read", 8'h1e, rd);
  endtask
  task automatic t_halt;
    logic [12:0] p;
    logic m;
    int k = 0;
    @(posedge i_mclk) i_halt_n <= 0;
    repeat (45) @(negedge i_mclk);
    p = pa;
    m = mc;
    repeat (80) @(negedge i_mclk) begin
      k += int'(mc && !m);
      m = mc;
    end
    chk("halt addr", p, pa);
    chk("halt en", 3, en);
    chk("mclk rises", 2, 16'(k));
    @(posedge i_mclk) i_halt_n <= 1;
  endtask
  initial begin
    @(posedge i_mclk);
    rst_chk;
    repeat (45) @(negedge i_mclk);
    chk("first addr", 16'h1000, pa);
    t_sel;
    t_wr;
    t_halt;
    @(posedge i_mclk) i_reset <= 1;
    @(posedge i_mclk);
    rst_chk;
    t_sel;
    t_rst_now;
    close_out;
  end
endmodule
bind mvb_port mvb_port_props u_props (.i_mclk, .i_reset, .i_halt_n, .o_program_address_lines,
  .o_vector_bus_n, .o_vector_bus_oe_n, .o_address_select_strobe, .o_data_write_strobe,
  .o_left_group_enable_n, .o_right_group_enable_n, .o_master_clock);
